// ==== bench/pps_guard_test.sv ====
/*
  Self-checking bench of the panel power guard: status, refusal, routing
  protection, key, interrupt. Assumes the panel model drives the asset inputs.
*/
`default_nettype none
module pps_guard_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] ST = pps_pkg::PPS_STAT_OFF;  // Short address aliases
  localparam logic [19:0] CT = pps_pkg::PPS_CTRL_OFF;
  localparam logic [19:0] RT = pps_pkg::PPS_ROUTE_OFF;
  localparam logic [19:0] FL = pps_pkg::PPS_IRQ_OFF;
  localparam logic [19:0] MK = pps_pkg::PPS_MASK_OFF;
  logic clock = 1'b0;
  logic rst = 1'b1;
  pps_pkg::pps_bus_req_t bus_req = '0;
  logic [1:0] port_select = 2'h0;
  logic [1:0] panel_xcoder = 2'h1;
  logic ask_pll = 1'b0;  // Bench asks the model for a locked PLL
  logic ask_port = 1'b0;
  logic [31:0] rd_data_q;
  logic pll_enabled, pll_locked, port_enabled, panel_vdd_q, protect_q, irq_q;
  logic [11:0] route_q;
  logic [31:0] seed = 32'h26084CF7;
  logic [31:0] rd, rt, nw;
  int n_fail = 0;
  int checks = 0;

  // Clock, 40 ns period
  always #20 clock = ~clock;

  pps_guard #(.UP_CYCLES(3), .DOWN_CYCLES(3), .CYCLE_CYCLES(8)) i_dut (
    .clock(clock), .rst(rst), .bus_req(bus_req), .rd_data_q(rd_data_q),
    .pll_enabled(pll_enabled), .pll_locked(pll_locked), .port_select(port_select),
    .port_enabled(port_enabled), .panel_xcoder(panel_xcoder), .panel_vdd_q(panel_vdd_q),
    .protect_q(protect_q), .route_q(route_q), .irq_q(irq_q));

  pps_panel_model i_panel (
    .clock(clock), .rst(rst), .ask_pll(ask_pll), .ask_port(ask_port),
    .pll_enabled(pll_enabled), .pll_locked(pll_locked), .port_enabled(port_enabled));

  // Repeatable random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Routing readback: the attached transcoder's pair is kept while guarded
  function automatic logic [31:0] route_exp(input logic [31:0] old, input logic [31:0] nv,
      input logic [1:0] x, input logic prot);
    logic [31:0] keep;
    keep = (prot && x != 2'h3) ? (32'h9 << (4 * x)) : 32'h0;
    return ((nv & ~keep) | (old & keep)) & 32'h999;
  endfunction : route_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb

  // One-cycle write strobe
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe; the data stand in the next cycle and are taken at its closing edge
  task automatic rdr(input logic [19:0] a, output logic [31:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    @(posedge clock);
    d = rd_data_q;
  endtask : rdr

  // Read status until bit b equals v, bounded
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    rdr(ST, rd);
    while (rd[b] !== v && n < 40) begin
      rdr(ST, rd);
      n++;
    end
    chkb(rd[b], v);
  endtask : poll

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // Watchdog, far beyond the expected 250 cycles
  initial begin
    #(40 * 8000);
    n_fail++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rdr(ST, rd);
    chk(rd, 32'h08000000);
    rdr(CT, rd);
    chk(rd, 32'h0);
    rdr(RT, rd);
    chk(rd, 32'h0);
    poll(27, 1'b0);
    $display("reset test done");
    // Refused power-up raises an unmasked event
    wr(MK, 32'h5);
    wr(CT, 32'h1);
    repeat (3) @(posedge clock);
    chkb(irq_q, 1'b1);
    rdr(ST, rd);
    chk({27'h0, rd[31:27]}, 32'h0);
    wr(CT, 32'h0);
    wr(FL, 32'h7);
    repeat (2) @(posedge clock);
    chkb(irq_q, 1'b0);
    $display("refusal test done");
    // Asset readiness over all PLL, port and select combinations
    for (int i = 0; i < 16; i++) begin
      ask_pll <= i[0];
      ask_port <= i[1];
      port_select <= i[3:2];
      repeat (6) @(posedge clock);
      rdr(ST, rd);
      chkb(rd[30], i[0] && (i[1] || i[3:2] == pps_pkg::PPS_PORT_DPA));
      chk({1'b0, rd[31], rd[29:0]}, 32'h0);
    end
    // Power-up runs on the LVDS port, where the asset bit may be trusted
    port_select <= 2'h0;
    $display("asset test done");
    // Routing while off, then a status write that must not land
    rt = xs();
    wr(RT, rt);
    rdr(RT, rd);
    chk(rd, route_exp(32'h0, rt, 2'h1, 1'b0));
    chk({20'h0, route_q}, route_exp(32'h0, rt, 2'h1, 1'b0));
    rt = rd;
    wr(ST, xs());
    rdr(ST, rd);
    chk(rd, 32'h40000000);
    rdr(20'hC7300, rd);
    chk(rd, 32'h0);
    // Power up
    wr(CT, 32'h1);
    poll(31, 1'b1);
    chk({30'h0, rd[29:28]}, 32'h1);
    poll(28, 1'b0);
    chkb(protect_q, 1'b1);
    chkb(panel_vdd_q, 1'b1);
    chkb(irq_q, 1'b1);
    wr(FL, 32'h1);
    // Guarded routing for every attachment
    for (int x = 0; x < 4; x++) begin
      panel_xcoder <= x[1:0];
      nw = xs();
      wr(RT, nw);
      rdr(RT, rd);
      chk(rd, route_exp(rt, nw, x[1:0], 1'b1));
      rt = rd;
    end
    panel_xcoder <= 2'h1;
    nw = xs();
    wr(CT, {nw[15:0] ^ ((nw[15:0] == 16'hABCD) ? 16'h1 : 16'h0), 16'h1});
    repeat (2) @(posedge clock);
    chkb(protect_q, 1'b1);
    wr(CT, 32'hABCD0001);
    repeat (2) @(posedge clock);
    chkb(protect_q, 1'b0);
    nw = xs();
    wr(RT, nw);
    rdr(RT, rd);
    chk(rd, route_exp(rt, nw, 2'h1, 1'b0));
    chkb(irq_q, 1'b0);
    $display("power up test done");
    // Power down, cycle delay, masked completion event
    wr(CT, 32'h0);
    poll(29, 1'b1);
    chk({28'h0, rd[31:28]}, 32'hE);
    chkb(protect_q, 1'b1);
    poll(31, 1'b0);
    chkb(rd[27], 1'b1);
    poll(27, 1'b0);
    rdr(FL, rd);
    chk(rd & 32'h7, 32'h2);
    chkb(irq_q, 1'b0);
    ask_port <= 1'b0;
    chkb(protect_q, 1'b0);
    chkb(panel_vdd_q, 1'b0);
    $display("power down test done");
    test_done();
  end
endmodule : pps_guard_test
`default_nettype wire

// ==== bench/pps_panel_model.sv ====
/*
  Panel side model: a display PLL that locks a few cycles after it is enabled,
  and the panel port. Assumes the bench asks for both; lock drops at once on disable.
*/
`default_nettype none
module pps_panel_model #(
  parameter int LOCK = 3  // Cycles from PLL request to lock
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Requests from the bench
  input wire logic ask_pll,
  input wire logic ask_port,
  // Asset state seen by the sequencer
  output logic pll_enabled,
  output logic pll_locked,
  output logic port_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;  // Lock counter, saturates at LOCK

  // Assets follow the requests one cycle late, as a real port would
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      pll_enabled <= 1'b0;
      port_enabled <= 1'b0;
    end else begin
      pll_enabled <= ask_pll;
      port_enabled <= ask_port;
      cnt <= !ask_pll ? 0 : (cnt < LOCK) ? cnt + 1 : cnt;
    end
  end

  // Lock never shows before the PLL has run LOCK-1 cycles, LOCK cycles after the request
  assign pll_locked = pll_enabled && cnt >= LOCK;
endmodule : pps_panel_model
`default_nettype wire

// ==== common/pps_pkg.sv ====
/*
  Shared constants and types of the panel power status and write guard block:
  register offsets, field positions, reset values and the bus request carrier.
  Assumes a single synchronous register port with 32-bit data and byte addresses.
*/
`default_nettype none
package pps_pkg;
  // Register byte addresses
  localparam logic [19:0] PPS_ROUTE_OFF = 20'hC7000;  // Transcoder PLL routing
  localparam logic [19:0] PPS_STAT_OFF = 20'hC7200;   // Panel power status, read only
  localparam logic [19:0] PPS_CTRL_OFF = 20'hC7204;   // Panel power control
  localparam logic [19:0] PPS_IRQ_OFF = 20'hC7210;    // Event flags, write one to clear
  localparam logic [19:0] PPS_MASK_OFF = 20'hC7214;   // Event mask, one lets it through

  // Reset values
  localparam logic [31:0] PPS_ROUTE_RST = 32'h00000000;
  localparam logic [31:0] PPS_CTRL_RST = 32'h00000000;
  localparam logic [31:0] PPS_STAT_RST = 32'h08000000;

  // Status register fields
  localparam int PPS_ST_ON_BIT = 31;      // Panel powered, powering up or powering down
  localparam int PPS_ST_ASSET_BIT = 30;   // PLL and port ready
  localparam int PPS_ST_PROG_LSB = 28;    // Two-bit sequence progress
  localparam int PPS_ST_CYC_BIT = 27;     // Power cycle delay running

  // Progress encodings
  localparam logic [1:0] PPS_PROG_IDLE = 2'h0;
  localparam logic [1:0] PPS_PROG_UP = 2'h1;
  localparam logic [1:0] PPS_PROG_DOWN = 2'h2;

  // Control register fields
  localparam int PPS_CT_KEY_LSB = 16;            // Sixteen-bit protect key
  localparam logic [15:0] PPS_UNLOCK_KEY = 16'hABCD;
  localparam logic [31:0] PPS_CTRL_WMASK = 32'hFFFF000F;  // Key plus four control bits
  localparam int PPS_CT_TARGET_BIT = 0;          // Power state target

  // Routing register: per transcoder select at 4*i, enable at 4*i+3
  localparam int PPS_NUM_XCODER = 3;
  localparam int PPS_RT_SEL_LSB = 0;
  localparam int PPS_RT_EN_LSB = 3;
  localparam int PPS_RT_STRIDE = 4;

  // Panel port select encodings
  localparam logic [1:0] PPS_PORT_DPA = 2'h1;

  // Event flag positions
  localparam int PPS_EV_ON = 0;       // Power up finished
  localparam int PPS_EV_OFF = 1;      // Power down finished
  localparam int PPS_EV_REFUSE = 2;   // Power up refused
  localparam int PPS_NUM_EV = 3;

  // Register port request
  typedef struct packed {
    logic wr;            // Write strobe
    logic rd;            // Read strobe
    logic [19:0] addr;   // Byte address
    logic [31:0] wdata;  // Write data
  } pps_bus_req_t;
endpackage : pps_pkg
`default_nettype wire

// ==== hw/pps_guard.sv ====
/*
  Panel power status and write guard: a compact power sequencer state machine,
  status and control registers, the transcoder PLL routing register with
  per-transcoder protection, an event interrupt, and the protect level that
  other guarded registers use to drop writes.
  Assumes one clock, inputs synchronous to it, and a master that keeps strobes
  one cycle long and never both at once.
*/
`default_nettype none
module pps_guard #(
  parameter int UP_CYCLES = 8,       // Power-up sequence length
  parameter int DOWN_CYCLES = 8,     // Power-down sequence length
  parameter int CYCLE_CYCLES = 16    // Power cycle delay length
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire pps_pkg::pps_bus_req_t bus_req,
  output logic [31:0] rd_data_q,
  // Panel assets
  input wire logic pll_enabled,           // Panel's display PLL enabled
  input wire logic pll_locked,            // Panel's display PLL locked
  input wire logic [1:0] port_select,     // Panel port: LVDS, DP A, DP C, DP D
  input wire logic port_enabled,          // Selected port enabled
  input wire logic [1:0] panel_xcoder,    // Transcoder feeding the panel, 3 none
  // Panel and system outputs
  output logic panel_vdd_q,               // Panel supply on
  output logic protect_q,                 // Guarded registers drop writes
  output logic [11:0] route_q,            // Transcoder PLL routing bits
  output logic irq_q                      // Level interrupt
);
  // Sequencer states, adjacent codes along power-up and power-down
  typedef enum logic [2:0] {
    PPS_OFF = 3'h0,
    PPS_UP = 3'h1,
    PPS_ON = 3'h3,
    PPS_DOWN = 3'h7,
    PPS_CYCLE = 3'h6
  } pps_state_t;

  // The sequence counter is sixteen bits, so longer or empty phases cannot be served
  if (UP_CYCLES < 1 || DOWN_CYCLES < 1 || CYCLE_CYCLES < 1 ||
      UP_CYCLES > 65535 || DOWN_CYCLES > 65535 || CYCLE_CYCLES > 65535) begin : g_bad_len
    $error("pps_guard: sequence lengths must lie in 1..65535");
  end

  pps_state_t state_q;            // Sequencer state
  logic [15:0] count_q;           // Cycles left in current timed state
  localparam int PPS_NUM_EV_W = pps_pkg::PPS_NUM_EV;
  logic [31:0] ctrl_q;            // Control register
  logic [PPS_NUM_EV_W-1:0] ev_q;  // Sticky event flags
  logic [PPS_NUM_EV_W-1:0] mask_q;  // Event mask

  logic key_ok;        // Unlock key present
  logic panel_on;      // Status on bit
  logic port_ok;       // Selected port usable
  logic asset_ready;   // Status asset bit
  logic start_ok;      // Power-up may begin
  logic wants_on;      // Target is on
  logic [1:0] progress;  // Status progress field
  logic [31:0] status;   // Status word as read
  logic [PPS_NUM_EV_W-1:0] ev_set;  // Events this cycle
  logic wr_route, wr_ctrl, wr_irq, wr_mask;  // Decoded writes

  // Unlock only on exact key; zero and all else keep protection
  assign key_ok = ctrl_q[pps_pkg::PPS_CT_KEY_LSB +: 16] == pps_pkg::PPS_UNLOCK_KEY;
  // Powered, powering up or still powering down reads as on
  assign panel_on = state_q == PPS_UP || state_q == PPS_ON || state_q == PPS_DOWN;
  // Port A counts as ready even when its enable is not reported
  assign port_ok = port_enabled || port_select == pps_pkg::PPS_PORT_DPA;
  assign asset_ready = pll_enabled && pll_locked && port_ok;
  // The key lets software force power-up past missing assets
  assign start_ok = asset_ready || key_ok;
  assign wants_on = ctrl_q[pps_pkg::PPS_CT_TARGET_BIT];

  // Progress field from state; the fourth code never appears
  always_comb begin
    case (state_q)
      PPS_UP: progress = pps_pkg::PPS_PROG_UP;
      PPS_DOWN: progress = pps_pkg::PPS_PROG_DOWN;
      default: progress = pps_pkg::PPS_PROG_IDLE;
    endcase
  end

  // Status word, reserved bits zero
  always_comb begin
    status = 32'h00000000;
    status[pps_pkg::PPS_ST_ON_BIT] = panel_on;
    status[pps_pkg::PPS_ST_ASSET_BIT] = asset_ready;
    status[pps_pkg::PPS_ST_PROG_LSB +: 2] = progress;
    status[pps_pkg::PPS_ST_CYC_BIT] = state_q == PPS_CYCLE;
  end

  // Write decode; a write to status matches nothing and is dropped
  assign wr_route = bus_req.wr && bus_req.addr == pps_pkg::PPS_ROUTE_OFF;
  assign wr_ctrl = bus_req.wr && bus_req.addr == pps_pkg::PPS_CTRL_OFF;
  assign wr_irq = bus_req.wr && bus_req.addr == pps_pkg::PPS_IRQ_OFF;
  assign wr_mask = bus_req.wr && bus_req.addr == pps_pkg::PPS_MASK_OFF;

  // Sequencer; reset lands in the cycle delay with default timing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= PPS_CYCLE;
      count_q <= 16'(CYCLE_CYCLES - 1);
    end else begin
      case (state_q)
        PPS_OFF: begin
          // Off: start only when the preconditions hold
          if (wants_on && start_ok) begin
            state_q <= PPS_UP;
            count_q <= 16'(UP_CYCLES - 1);
          end
        end
        PPS_UP: begin
          // Power-up runs to the end even if the target drops
          if (count_q == 16'h0000) begin
            state_q <= PPS_ON;
          end else begin
            count_q <= count_q - 16'h0001;
          end
        end
        PPS_ON: begin
          if (!wants_on) begin
            state_q <= PPS_DOWN;
            count_q <= 16'(DOWN_CYCLES - 1);
          end
        end
        PPS_DOWN: begin
          // Every finished power-down is followed by a cycle delay
          if (count_q == 16'h0000) begin
            state_q <= PPS_CYCLE;
            count_q <= 16'(CYCLE_CYCLES - 1);
          end else begin
            count_q <= count_q - 16'h0001;
          end
        end
        PPS_CYCLE: begin
          if (count_q == 16'h0000) begin
            state_q <= PPS_OFF;
          end else begin
            count_q <= count_q - 16'h0001;
          end
        end
        default: begin
          state_q <= PPS_CYCLE;
          count_q <= 16'(CYCLE_CYCLES - 1);
        end
      endcase
    end
  end

  // Control register; never protected so the key can always be written
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= pps_pkg::PPS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= bus_req.wdata & pps_pkg::PPS_CTRL_WMASK;
    end
  end

  // Routing register, one field group per transcoder
  logic [11:0] route_live;  // Bits that hold a select or an enable
  logic [11:0] route_hold;  // Bits that a write must leave alone this cycle
  genvar gi;
  generate
    for (gi = 0; gi < pps_pkg::PPS_NUM_XCODER; gi++) begin : g_route
      localparam int SB = gi * pps_pkg::PPS_RT_STRIDE + pps_pkg::PPS_RT_SEL_LSB;
      localparam int EB = gi * pps_pkg::PPS_RT_STRIDE + pps_pkg::PPS_RT_EN_LSB;
      logic guard;  // This transcoder's bits are locked
      // Locked only while the panel hangs on this transcoder
      assign guard = panel_on && !key_ok && panel_xcoder == 2'(gi);
      // Select and enable are stored; the two bits between them stay zero
      assign route_live[SB] = 1'b1;
      assign route_live[EB] = 1'b1;
      assign route_live[EB-1:SB+1] = 2'h0;
      assign route_hold[SB] = guard;
      assign route_hold[EB] = guard;
      assign route_hold[EB-1:SB+1] = 2'h0;
    end
  endgenerate

  // One word of flip-flops, so reserved bits also leave a register as zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      route_q <= pps_pkg::PPS_ROUTE_RST[11:0];
    end else if (wr_route) begin
      route_q <= (bus_req.wdata[11:0] & route_live & ~route_hold) | (route_q & route_hold);
    end
  end

  // Protect level for the guarded timing, port, delay and divisor registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      protect_q <= 1'b0;
    end else begin
      // An unused port other than DP A never leaves off without the key, so this stays low until a control write drops the key
      protect_q <= panel_on && !key_ok;
    end
  end

  // Panel supply follows the powered states
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      panel_vdd_q <= 1'b0;
    end else begin
      panel_vdd_q <= panel_on;
    end
  end

  // Events: power-up done, power-down done, power-up refused
  always_comb begin
    ev_set = '0;
    ev_set[pps_pkg::PPS_EV_ON] = state_q == PPS_UP && count_q == 16'h0000;
    ev_set[pps_pkg::PPS_EV_OFF] = state_q == PPS_DOWN && count_q == 16'h0000;
    ev_set[pps_pkg::PPS_EV_REFUSE] = state_q == PPS_OFF && wants_on && !start_ok;
  end

  // Sticky flags; an event in the clearing cycle survives
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ev_q <= '0;
    end else if (wr_irq) begin
      ev_q <= (ev_q & ~bus_req.wdata[PPS_NUM_EV_W-1:0]) | ev_set;
    end else begin
      ev_q <= ev_q | ev_set;
    end
  end

  // Mask register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= bus_req.wdata[PPS_NUM_EV_W-1:0];
    end
  end

  // Interrupt lags the flags by one cycle so it leaves a flip-flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ev_q & mask_q);
    end
  end

  // Read data in the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data_q <= 32'h00000000;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        pps_pkg::PPS_ROUTE_OFF: rd_data_q <= {20'h00000, route_q};
        pps_pkg::PPS_STAT_OFF: rd_data_q <= status;
        pps_pkg::PPS_CTRL_OFF: rd_data_q <= ctrl_q;
        pps_pkg::PPS_IRQ_OFF: rd_data_q <= {{(32 - PPS_NUM_EV_W){1'b0}}, ev_q};
        pps_pkg::PPS_MASK_OFF: rd_data_q <= {{(32 - PPS_NUM_EV_W){1'b0}}, mask_q};
        default: rd_data_q <= 32'h00000000;
      endcase
    end else begin
      rd_data_q <= 32'h00000000;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  on_status_a: assert property (
    $fell(panel_on) |-> $past(state_q) == PPS_DOWN && state_q == PPS_CYCLE)
    else $error("on status dropped before power-down finished");
  protect_lvl_a: assert property (
    ##1 protect_q == $past(panel_on && !key_ok))
    else $error("protect level does not follow on status and key");
  asset_rdy_a: assert property (
    bus_req.rd && bus_req.addr == pps_pkg::PPS_STAT_OFF |=>
      rd_data_q[pps_pkg::PPS_ST_ASSET_BIT] == $past(pll_enabled && pll_locked &&
      (port_enabled || port_select == pps_pkg::PPS_PORT_DPA)))
    else $error("asset ready read back without PLL and port");
  refuse_up_a: assert property (
    state_q == PPS_OFF && !asset_ready && !key_ok |=> state_q != PPS_UP)
    else $error("power-up started without assets or key");
  cycle_after_a: assert property (
    state_q == PPS_DOWN && count_q == 16'h0000 |=> state_q == PPS_CYCLE &&
      status[pps_pkg::PPS_ST_CYC_BIT])
    else $error("no cycle delay after power-down");
  route_keep_a: assert property (
    wr_route && panel_on && !key_ok && panel_xcoder == 2'h1 |=>
      route_q[7:4] == $past(route_q[7:4]))
    else $error("attached transcoder routing bits changed");
  route_free_a: assert property (
    wr_route && panel_xcoder != 2'h0 |=> route_q[3] == $past(bus_req.wdata[3]))
    else $error("unguarded routing enable not stored");
  prog_code_a: assert property (
    status[29:28] != 2'h3)
    else $error("reserved progress code produced");
  status_ro_a: assert property (
    bus_req.wr && bus_req.addr == pps_pkg::PPS_STAT_OFF |=> $stable(ctrl_q) &&
      $stable(mask_q) && $stable(route_q) && ev_q == $past(ev_q | ev_set))
    else $error("status write changed state");
  key_only_a: assert property (
    panel_on && ctrl_q[pps_pkg::PPS_CT_KEY_LSB +: 16] != pps_pkg::PPS_UNLOCK_KEY |=> protect_q)
    else $error("protection lifted without key");

  up_cv: cover property (state_q == PPS_OFF ##1 state_q == PPS_UP);
  down_cv: cover property (state_q == PPS_DOWN ##1 state_q == PPS_CYCLE);
  refuse_cv: cover property (ev_set[pps_pkg::PPS_EV_REFUSE] && wr_irq);
  key_cv: cover property (panel_on && key_ok && wr_route);
endmodule : pps_guard
`default_nettype wire
